/* File: src/accel_pkg.sv */
package accel_pkg;
    // spi command bytes and register addresses
    localparam logic [7:0] CMD_WRITE = 8'h0a;
    localparam logic [7:0] CMD_READ = 8'h0b;
    localparam logic [7:0] ADDR_STATUS = 8'h0b;
    localparam logic [7:0] ADDR_ACT_THR_L = 8'h20;
    localparam logic [7:0] ADDR_ACT_THR_H = 8'h21;
    localparam logic [7:0] ADDR_ACT_TIME = 8'h22;
    localparam logic [7:0] ADDR_INACT_THR_L = 8'h23;
    localparam logic [7:0] ADDR_INACT_THR_H = 8'h24;
    localparam logic [7:0] ADDR_INACT_TIME_L = 8'h25;
    localparam logic [7:0] ADDR_INACT_TIME_H = 8'h26;
    localparam logic [7:0] ADDR_MOTION = 8'h27;
    localparam logic [7:0] ADDR_BUF_CTL = 8'h28;
    localparam logic [7:0] ADDR_BUF_CNT = 8'h29;
    localparam logic [7:0] ADDR_ROUTE_FIRST = 8'h2a;
    localparam logic [7:0] ADDR_ROUTE_SECOND = 8'h2b;
    localparam logic [7:0] ADDR_FILTER = 8'h2c;
    localparam logic [7:0] ADDR_POWER = 8'h2d;
    localparam int BANK_DEPTH = 14;

    // reset values
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_FILTER = 8'h03;

    // frame phases of the serial port
    localparam logic [1:0] PHASE_CMD = 2'h0;
    localparam logic [1:0] PHASE_ADDR = 2'h1;
    localparam logic [1:0] PHASE_DATA = 2'h2;

    // motion control fields
    localparam int MOT_ACT_EN = 0;
    localparam int MOT_ACT_REF = 1;
    localparam int MOT_INACT_EN = 2;
    localparam int MOT_INACT_REF = 3;
    localparam int MOT_LINK_LO = 4;
    localparam logic [1:0] LINK_DEFAULT = 2'h0;
    localparam logic [1:0] LINK_LINKED = 2'h1;
    localparam logic [1:0] LINK_LOOP = 2'h3;

    // power mode fields
    localparam int PWR_EXTERNAL_CLOCK_SELECT = 6;
    localparam int PWR_WAKE = 3;
    localparam int PWR_AUTOSLEEP = 2;
    localparam int PWR_MEASUREMENT_SELECT_LO = 0;
    localparam logic [1:0] MEASUREMENT_SELECT_ON = 2'h2;

    // filter, range and rate fields
    localparam int FLT_EXT_TRIG = 3;
    localparam int FLT_ODR_LO = 0;
    localparam logic [2:0] ODR_FASTEST = 3'h5;

    // routing and status bit positions
    localparam int ROUTE_LOW = 7;
    localparam int BIT_AWAKE = 6;
    localparam int BIT_INACT = 5;
    localparam int BIT_ACT = 4;
    localparam int THR_HIGH_BITS = 3;

    // timing: fastest rate is 400 Hz, wake-up rate is 1/64 of it
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned FAST_RATE_HZ = 400;
    localparam logic [2:0] WAKE_SHIFT = 3'h6;
    localparam int unsigned EXT_EDGES_FAST = 128;

    typedef struct packed {
        logic [7:0] act_thr_l;
        logic [7:0] act_thr_h;
        logic [7:0] act_time;
        logic [7:0] inact_thr_l;
        logic [7:0] inact_thr_h;
        logic [7:0] inact_time_l;
        logic [7:0] inact_time_h;
        logic [7:0] motion;
        logic [7:0] buf_ctl;
        logic [7:0] buf_cnt;
        logic [7:0] route_first;
        logic [7:0] route_second;
        logic [7:0] filter;
        logic [7:0] power;
    } cfg_t;

    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } sample_t;
endpackage

/* File: src/spi_link.sv */
`timescale 1ns/1ps
module spi_link (
    input wire logic spi_sclk,
    input wire logic reset_n,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    input wire logic [7:0] status_byte,
    output logic spi_miso,
    output logic spi_miso_oe,
    output accel_pkg::cfg_t cfg,
    output logic wr_tgl,
    output logic clr_tgl
);
    logic frame_rst_n;
    logic [2:0] bit_cnt_r;
    logic [1:0] byte_idx_r;
    logic [6:0] shift_r;
    logic [7:0] cmd_r;
    logic [7:0] addr_r;
    logic [7:0] tx_r;
    logic [7:0] bank_r [accel_pkg::BANK_DEPTH];
    logic [7:0] status_meta_r;
    logic [7:0] status_sync_r;
    logic wr_tgl_r;
    logic clr_tgl_r;
    logic miso_oe_r;
    logic [7:0] rx_byte;
    logic [7:0] rd_byte;
    logic [7:0] bank_off;
    logic [3:0] bank_idx;
    logic byte_done;
    logic data_phase;
    logic bank_hit;
    logic wr_hit;
    logic status_read;

    // frame state dies with chip select, since the link clock stops between frames
    assign frame_rst_n = reset_n & ~spi_cs_n;
    assign rx_byte = {shift_r, spi_mosi};
    assign byte_done = (bit_cnt_r == 3'h7);
    assign data_phase = (byte_idx_r == accel_pkg::PHASE_DATA);
    assign bank_hit = (addr_r >= accel_pkg::ADDR_ACT_THR_L) && (addr_r <= accel_pkg::ADDR_POWER);
    assign bank_off = addr_r - accel_pkg::ADDR_ACT_THR_L;
    assign bank_idx = bank_off[3:0];
    assign wr_hit = byte_done && data_phase && (cmd_r == accel_pkg::CMD_WRITE) && bank_hit;
    assign status_read = byte_done && data_phase && (cmd_r == accel_pkg::CMD_READ) &&
                         (addr_r == accel_pkg::ADDR_STATUS);
    assign rd_byte = (cmd_r != accel_pkg::CMD_READ) ? 8'h00 :
                     (addr_r == accel_pkg::ADDR_STATUS) ? status_sync_r :
                     bank_hit ? bank_r[bank_idx] : 8'h00;

    // command, address, then data bytes with address auto-increment
    always_ff @(posedge spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_r <= 3'h0;
            byte_idx_r <= accel_pkg::PHASE_CMD;
            shift_r <= 7'h00;
            cmd_r <= 8'h00;
            addr_r <= 8'h00;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r <= rx_byte[6:0];
            if (byte_done && byte_idx_r == accel_pkg::PHASE_CMD) begin
                cmd_r <= rx_byte;
                byte_idx_r <= accel_pkg::PHASE_ADDR;
            end else if (byte_done && byte_idx_r == accel_pkg::PHASE_ADDR) begin
                addr_r <= rx_byte;
                byte_idx_r <= accel_pkg::PHASE_DATA;
            end else if (byte_done) begin
                addr_r <= addr_r + 8'h01;
            end
        end
    end

    // register bank survives frame ends; each bank write and each status read flips a toggle
    always_ff @(posedge spi_sclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < accel_pkg::BANK_DEPTH; i++) begin
                bank_r[i] <= (i == int'(accel_pkg::ADDR_FILTER - accel_pkg::ADDR_ACT_THR_L)) ?
                             accel_pkg::RESET_FILTER : accel_pkg::RESET_ZERO;
            end
            wr_tgl_r <= 1'b0;
            clr_tgl_r <= 1'b0;
        end else begin
            if (wr_hit) begin
                bank_r[bank_idx] <= rx_byte;
            end
            wr_tgl_r <= wr_tgl_r ^ wr_hit;
            clr_tgl_r <= clr_tgl_r ^ status_read;
        end
    end

    // status is only two link edges stale, refreshed long before the data byte loads
    always_ff @(posedge spi_sclk or negedge reset_n) begin
        if (!reset_n) begin
            status_meta_r <= 8'h00;
            status_sync_r <= 8'h00;
        end else begin
            status_meta_r <= status_byte;
            status_sync_r <= status_meta_r;
        end
    end

    // read data changes on the falling edge so the master samples it on the rising one
    always_ff @(negedge spi_sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_r <= 8'h00;
            miso_oe_r <= 1'b0;
        end else begin
            miso_oe_r <= 1'b1;
            if (bit_cnt_r == 3'h0 && data_phase) begin
                tx_r <= rd_byte;
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    assign spi_miso = tx_r[7];
    assign spi_miso_oe = miso_oe_r;
    assign wr_tgl = wr_tgl_r;
    assign clr_tgl = clr_tgl_r;
    assign cfg = '{act_thr_l: bank_r[0], act_thr_h: bank_r[1], act_time: bank_r[2],
                   inact_thr_l: bank_r[3], inact_thr_h: bank_r[4], inact_time_l: bank_r[5],
                   inact_time_h: bank_r[6], motion: bank_r[7], buf_ctl: bank_r[8],
                   buf_cnt: bank_r[9], route_first: bank_r[10], route_second: bank_r[11],
                   filter: bank_r[12], power: bank_r[13]};
endmodule

/* File: src/accel_startup_configurator.sv */
`timescale 1ns/1ps
// Functional notes
// (R1) host writes thresholds, timers, motion, buffer, routing, general, then power last
// (R2) host should program activity time above one to cut false motion triggers
// (R3) motion switch: activity threshold low gets 0xfa, high gets zero
// (R4) motion switch: inactivity threshold low gets 0x96, high gets zero
// (R5) motion switch: inactivity timer gets 0x1e, thirty samples
// (R6) motion control 0x3f selects loop mode with referenced activity and inactivity
// (R7) second routing bit six puts the awake state on pin two
// (R8) power value 0x0a starts measuring in wake-up mode, then runs alone
// (R9) external clock mode takes all sample timing from pin one
// (R10) host sets power bit six last, e.g. 0x42, for external clock
// (R11) synchronized sampling takes one sample per trigger on pin two
// (R12) host sets filter bit three near the end, e.g. 0x4b
// (R13) absolute inactivity flags only when all axes stay below threshold long enough
// (R14) host sets inactivity threshold code as g times scale factor
// (R15) host sets inactivity time code as seconds times output rate
// (R16) free fall sets inactivity status and drives every pin it is routed to; here a pin used as clock or trigger input is not driven
// (R17) free fall: inactivity threshold 0x96 and timer 0x03
// (R18) free fall: motion control 0x04, absolute inactivity only
// (R19) host routes inactivity with 0x20 in first or second routing register
// (R20) free fall ends with filter 0x83 then power 0x02
// (R21) measurement field: 00 standby, 10 measurement_select, other codes reserved
// (R22) external trigger bit turns pin two into the conversion timing input
// (R23) autosleep counts only in linked or loop mode; inactivity then forces wake-up rate
// (R24) rate field 011 is 100 Hz at reset, codes step 12.5 Hz to 400 Hz
// (R25) host sequencer finishes each write before the next, done after power write
module accel_startup_configurator #(
    parameter int unsigned SAMPLE_PERIOD_FAST = accel_pkg::CLK_HZ / accel_pkg::FAST_RATE_HZ
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    input wire logic int_one_in,
    output logic int_one_out,
    output logic int_one_oe,
    input wire logic int_two_in,
    output logic int_two_out,
    output logic int_two_oe,
    input wire accel_pkg::sample_t accel_in,
    output accel_pkg::sample_t sample_out,
    output logic sample_valid
);
    accel_pkg::cfg_t link_cfg;
    accel_pkg::cfg_t cfg_r;
    accel_pkg::sample_t sample_r;
    accel_pkg::sample_t ref_r;
    logic link_wr_tgl;
    logic link_clr_tgl;
    logic [2:0] wr_sync_r;
    logic [2:0] clr_sync_r;
    logic [2:0] one_sync_r;
    logic [2:0] two_sync_r;
    logic [23:0] tick_cnt_r;
    logic [23:0] tick_cnt_nxt;
    logic sample_valid_r;
    logic eval_r;
    logic [7:0] act_run_r;
    logic [15:0] inact_run_r;
    logic act_flag_r;
    logic inact_flag_r;
    logic awake_r;
    logic [7:0] status_r;
    logic one_out_r;
    logic one_oe_r;
    logic two_out_r;
    logic two_oe_r;

    // absolute deviation of one axis, against the reference when asked
    function automatic logic [12:0] axis_dev(input logic signed [11:0] a, input logic signed [11:0] r,
                                             input logic use_ref);
        logic signed [12:0] d;
        d = use_ref ? (13'(a) - 13'(r)) : 13'(a);
        axis_dev = d[12] ? 13'(-d) : 13'(d);
    endfunction

    function automatic logic any_above(input accel_pkg::sample_t s, input accel_pkg::sample_t r,
                                       input logic use_ref, input logic [10:0] thr);
        any_above = (axis_dev(s.x, r.x, use_ref) > {2'b00, thr}) ||
                    (axis_dev(s.y, r.y, use_ref) > {2'b00, thr}) ||
                    (axis_dev(s.z, r.z, use_ref) > {2'b00, thr});
    endfunction

    function automatic logic all_below(input accel_pkg::sample_t s, input accel_pkg::sample_t r,
                                       input logic use_ref, input logic [10:0] thr);
        all_below = (axis_dev(s.x, r.x, use_ref) < {2'b00, thr}) &&
                    (axis_dev(s.y, r.y, use_ref) < {2'b00, thr}) &&
                    (axis_dev(s.z, r.z, use_ref) < {2'b00, thr});
    endfunction

    spi_link u_link (
        .spi_sclk(spi_sclk),
        .reset_n(reset_n),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .status_byte(status_r),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .cfg(link_cfg),
        .wr_tgl(link_wr_tgl),
        .clr_tgl(link_clr_tgl)
    );

    // toggles from the link and both pins pass two flops; the third flop only finds edges
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wr_sync_r <= 3'h0;
            clr_sync_r <= 3'h0;
            one_sync_r <= 3'h0;
            two_sync_r <= 3'h0;
        end else begin
            wr_sync_r <= {wr_sync_r[1:0], link_wr_tgl};
            clr_sync_r <= {clr_sync_r[1:0], link_clr_tgl};
            one_sync_r <= {one_sync_r[1:0], int_one_in};
            two_sync_r <= {two_sync_r[1:0], int_two_in};
        end
    end

    logic wr_seen;
    logic clr_seen;
    logic one_rise;
    logic two_rise;
    assign wr_seen = wr_sync_r[2] ^ wr_sync_r[1];
    assign clr_seen = clr_sync_r[2] ^ clr_sync_r[1];
    assign one_rise = one_sync_r[1] & ~one_sync_r[2];
    assign two_rise = two_sync_r[1] & ~two_sync_r[2];

    // the bank is copied once its toggle has settled; a following write needs eight more
    // link edges, so at the bench link rate the word is stable while it is taken
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= '{filter: accel_pkg::RESET_FILTER, default: accel_pkg::RESET_ZERO};
        end else if (wr_seen) begin
            cfg_r <= link_cfg;
        end
    end

    // mode decode
    logic measuring;
    logic external_clock_select;
    logic ext_trig;
    logic [1:0] link_mode;
    logic link_active;
    logic wake_eff;
    logic [2:0] odr;
    logic [2:0] rate_shift;
    logic [23:0] base_period;
    logic [23:0] period;
    logic step;
    logic timer_tick;
    logic sample_tick;
    assign measuring = (cfg_r.power[accel_pkg::PWR_MEASUREMENT_SELECT_LO +: 2] == accel_pkg::MEASUREMENT_SELECT_ON); // [R21] [R8]
    assign external_clock_select = cfg_r.power[accel_pkg::PWR_EXTERNAL_CLOCK_SELECT];
    assign ext_trig = cfg_r.filter[accel_pkg::FLT_EXT_TRIG];
    assign link_mode = cfg_r.motion[accel_pkg::MOT_LINK_LO +: 2];
    assign link_active = (link_mode == accel_pkg::LINK_LINKED) || (link_mode == accel_pkg::LINK_LOOP);
    // autosleep is ignored outside linked or loop mode
    assign wake_eff = cfg_r.power[accel_pkg::PWR_WAKE] |
                      (cfg_r.power[accel_pkg::PWR_AUTOSLEEP] & link_active & ~awake_r); // [R23] [R8]
    assign odr = cfg_r.filter[accel_pkg::FLT_ODR_LO +: 3];
    // each rate code below the fastest halves the rate; codes above it stay at 400 Hz
    assign rate_shift = wake_eff ? accel_pkg::WAKE_SHIFT :
                        (odr >= accel_pkg::ODR_FASTEST) ? 3'h0 : (accel_pkg::ODR_FASTEST - odr); // [R24]
    // external clock edges replace the system clock as the unit of time
    assign base_period = external_clock_select ? 24'(accel_pkg::EXT_EDGES_FAST) : 24'(SAMPLE_PERIOD_FAST); // [R9]
    assign period = base_period << rate_shift;
    assign step = external_clock_select ? one_rise : 1'b1; // [R9]
    assign timer_tick = step && (tick_cnt_r >= period - 24'h1);
    assign tick_cnt_nxt = (!measuring || timer_tick) ? 24'h0 : (tick_cnt_r + {23'h0, step});
    // with the trigger selected, pin two alone paces conversions
    assign sample_tick = measuring && (ext_trig ? two_rise : timer_tick); // [R11] [R22]

    // sample timer and capture; standby holds the timer at zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt_r <= 24'h0;
            sample_r <= '0;
            sample_valid_r <= 1'b0;
            eval_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            sample_valid_r <= sample_tick;
            eval_r <= sample_tick;
            if (sample_tick) begin
                sample_r <= accel_in; // [R11]
            end
        end
    end

    // detection terms on the captured sample
    logic [10:0] act_thr;
    logic [10:0] inact_thr;
    logic [7:0] act_need;
    logic [15:0] inact_need;
    logic act_look;
    logic inact_look;
    logic above;
    logic below;
    logic act_hit;
    logic inact_hit;
    assign act_thr = {cfg_r.act_thr_h[accel_pkg::THR_HIGH_BITS-1:0], cfg_r.act_thr_l};
    assign inact_thr = {cfg_r.inact_thr_h[accel_pkg::THR_HIGH_BITS-1:0], cfg_r.inact_thr_l};
    // a zero time still needs one qualifying sample
    assign act_need = (cfg_r.act_time == 8'h00) ? 8'h01 : cfg_r.act_time;
    assign inact_need = ({cfg_r.inact_time_h, cfg_r.inact_time_l} == 16'h0000) ? 16'h0001 :
                        {cfg_r.inact_time_h, cfg_r.inact_time_l};
    // linked and loop modes only look for the opposite of the present state
    assign act_look = cfg_r.motion[accel_pkg::MOT_ACT_EN] && !(link_active && awake_r);
    assign inact_look = cfg_r.motion[accel_pkg::MOT_INACT_EN] && !(link_active && !awake_r);
    assign above = any_above(sample_r, ref_r, cfg_r.motion[accel_pkg::MOT_ACT_REF], act_thr);
    // absolute mode compares raw magnitude on every axis, which is the free fall test
    assign below = all_below(sample_r, ref_r, cfg_r.motion[accel_pkg::MOT_INACT_REF], inact_thr); // [R13]
    assign act_hit = eval_r && act_look && above && (act_run_r + 8'h01 >= act_need);
    assign inact_hit = eval_r && inact_look && below && (inact_run_r + 16'h0001 >= inact_need); // [R13]

    // consecutive-sample runs; one miss restarts the count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            act_run_r <= 8'h00;
            inact_run_r <= 16'h0000;
        end else if (!measuring) begin
            act_run_r <= 8'h00;
            inact_run_r <= 16'h0000;
        end else if (eval_r) begin
            act_run_r <= (act_look && above && !act_hit) ? act_run_r + 8'h01 : 8'h00;
            inact_run_r <= (inact_look && below && !inact_hit) ? inact_run_r + 16'h0001 : 16'h0000; // [R13]
        end
    end

    // sticky status: a detection in the same cycle as a status-read clear wins;
    // loop mode retires the opposite flag itself so the host need not read
    logic act_flag_nxt;
    logic inact_flag_nxt;
    logic loop_mode;
    assign loop_mode = (link_mode == accel_pkg::LINK_LOOP);
    assign act_flag_nxt = act_hit | (act_flag_r & ~clr_seen & ~(loop_mode & inact_hit));
    assign inact_flag_nxt = inact_hit | (inact_flag_r & ~clr_seen & ~(loop_mode & act_hit)); // [R16]

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            act_flag_r <= 1'b0;
            inact_flag_r <= 1'b0;
            awake_r <= 1'b1;
            ref_r <= '0;
        end else begin
            act_flag_r <= act_flag_nxt;
            inact_flag_r <= inact_flag_nxt; // [R16]
            if (!link_active) begin
                awake_r <= 1'b1;
            end else if (act_hit) begin
                awake_r <= 1'b1;
            end else if (inact_hit) begin
                awake_r <= 1'b0;
            end
            // each detection re-bases the reference for the opposite detector
            if (act_hit || inact_hit) begin
                ref_r <= sample_r;
            end
        end
    end

    // pin levels: OR of routed sources, polarity from the top routing bit
    logic [2:0] src_bits;
    logic one_level;
    logic two_level;
    logic one_drive;
    logic two_drive;
    assign src_bits = {awake_r, inact_flag_r, act_flag_r};
    assign one_level = |(cfg_r.route_first[accel_pkg::BIT_AWAKE:accel_pkg::BIT_ACT] & src_bits); // [R16]
    assign two_level = |(cfg_r.route_second[accel_pkg::BIT_AWAKE:accel_pkg::BIT_ACT] & src_bits); // [R7] [R16]
    // an unrouted pin floats; a pin that serves as clock or trigger input never drives
    assign one_drive = (|cfg_r.route_first[accel_pkg::ROUTE_LOW-1:0]) && !external_clock_select; // [R9]
    assign two_drive = (|cfg_r.route_second[accel_pkg::ROUTE_LOW-1:0]) && !ext_trig; // [R22] [R7]

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            one_out_r <= 1'b0;
            one_oe_r <= 1'b0;
            two_out_r <= 1'b0;
            two_oe_r <= 1'b0;
            status_r <= 8'h00;
        end else begin
            one_out_r <= one_level ^ cfg_r.route_first[accel_pkg::ROUTE_LOW];
            one_oe_r <= one_drive;
            two_out_r <= two_level ^ cfg_r.route_second[accel_pkg::ROUTE_LOW]; // [R7]
            two_oe_r <= two_drive;
            status_r <= 8'h00;
            status_r[accel_pkg::BIT_AWAKE] <= awake_r;
            status_r[accel_pkg::BIT_INACT] <= inact_flag_r; // [R16]
            status_r[accel_pkg::BIT_ACT] <= act_flag_r;
        end
    end

    assign int_one_out = one_out_r;
    assign int_one_oe = one_oe_r;
    assign int_two_out = two_out_r;
    assign int_two_oe = two_oe_r;
    assign sample_out = sample_r;
    assign sample_valid = sample_valid_r;
endmodule

/* File: testbench/accel_startup_configurator_properties.sv */
`timescale 1ns/1ps
module accel_startup_configurator_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic spi_cs_n,
    input wire logic spi_miso_oe,
    input wire logic int_one_oe,
    input wire logic int_two_in,
    input wire logic int_two_oe,
    input wire accel_pkg::sample_t accel_in,
    input wire accel_pkg::sample_t sample_out,
    input wire logic sample_valid
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // link output, reset state and standby after reset
    a_frame_release: assert property (spi_cs_n |-> !spi_miso_oe)
        else $error("miso enabled outside a frame");
    a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> !(spi_miso_oe | int_two_oe | sample_valid))
        else $error("output active in reset");
    a_standby_first: assert property ($rose(reset_n) |-> !sample_valid [*8])
        else $error("sample while in standby");
    a_pins_released: assert property ($rose(reset_n) |-> (!int_one_oe && !int_two_oe) [*8])
        else $error("pin driven before routing");
    // samples: spacing, captured value, and trigger response
    a_pulse_spacing: assert property (sample_valid |=> !sample_valid [*8])
        else $error("samples too close");
    a_capture_value: assert property (sample_valid && $stable(accel_in) |-> sample_out == accel_in)
        else $error("sample value wrong");
    a_output_holds: assert property ($changed(sample_out) |-> sample_valid)
        else $error("sample changed without pulse");
    a_trigger_sample: assert property ($rose(int_two_in) && !int_two_oe |-> ##[1:8] sample_valid)
        else $error("no sample after trigger");
    c_sample: cover property (sample_valid);
    c_pin_two: cover property ($rose(int_two_oe));
    c_frame: cover property ($fell(spi_cs_n));
endmodule

/* File: testbench/spi_host_model.sv */
`timescale 1ns/1ps
// host end of the link; the link clock stands low between frames
module spi_host_model (
    output logic spi_sclk = 1'b0,
    output logic spi_cs_n = 1'b1,
    output logic spi_mosi = 1'b0,
    input wire logic spi_miso
);
    // one whole frame; the gap after it lets a write land before the next request
    task automatic xfer(input logic [7:0] cmd, adr, dat, output logic [7:0] rd);
        logic [23:0] sh;
        sh = {cmd, adr, dat};
        #13 spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi = sh[i];
            #32 spi_sclk = 1'b1;
            if (i < 8) rd[i] = spi_miso;
            #32 spi_sclk = 1'b0;
        end
        #32 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        #400;
    endtask
endmodule

/* File: testbench/accel_startup_configurator_tb.sv */
`timescale 1ns/1ps
module accel_startup_configurator_tb;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b1;
    logic ext_one = 1'b0;
    logic ext_two = 1'b0;
    accel_pkg::sample_t accel_in = '{12'sd5, -12'sd3, 12'sd9};
    accel_pkg::sample_t sample_out;
    wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, miso_w, sample_valid;
    wire int_one_in, int_one_out, int_one_oe, int_two_in, int_two_out, int_two_oe;
    int n_errors = 0;
    int n_compared = 0;
    int n_samples = 0;
    int k0;
    logic [7:0] rd_v;
    logic [15:0] ms [9] = '{16'h20fa, 16'h2100, 16'h2202, 16'h2396, 16'h2400, 16'h251e, 16'h273f, 16'h2b40, 16'h2d0a};
    logic [15:0] ff [7] = '{16'h2d00, 16'h2396, 16'h2503, 16'h2704, 16'h2a20, 16'h2c83, 16'h2d02};
    // pins carry whichever party drives them; miso idles high; samples are counted
    assign int_one_in = int_one_oe ? int_one_out : ext_one;
    assign int_two_in = int_two_oe ? int_two_out : ext_two;
    assign miso_w = spi_miso_oe ? spi_miso : 1'b1;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (sample_valid === 1'b1) n_samples++;
    accel_startup_configurator #(.SAMPLE_PERIOD_FAST(20)) DUT (.clk_sys, .reset_n, .spi_sclk, .spi_cs_n,
        .spi_mosi, .spi_miso, .spi_miso_oe, .int_one_in, .int_one_out, .int_one_oe, .int_two_in, .int_two_out,
        .int_two_oe, .accel_in, .sample_out, .sample_valid);
    spi_host_model host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso(miso_w));
    task automatic check(input string what, input logic [35:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] ad);
        host.xfer(accel_pkg::CMD_WRITE, ad[15:8], ad[7:0], rd_v);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        host.xfer(accel_pkg::CMD_READ, a, 8'h00, rd_v);
        check("register", {28'h0, rd_v}, {28'h0, exp});
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait: sel 0 for a sample pulse, 1 for pin one high
    task automatic wait_for(input int sel, input int lim);
        int k;
        for (k = 0; k < lim && ((sel == 0 ? sample_valid : int_one_out) !== 1'b1); k++) @(negedge clk_sys);
        if (k == lim) begin
            n_errors++;
            $display("wrong value wait %0d expected 1 seen 0", sel);
            final_report();
        end
    endtask
    initial begin
        #1 reset_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        @(negedge clk_sys);
        rd(accel_pkg::ADDR_FILTER, 8'h03);
        rd(accel_pkg::ADDR_POWER, 8'h00);
        rd(8'h30, 8'h00);
        $display("test reset values done");
        foreach (ms[i]) wr(ms[i]);
        foreach (ms[i]) rd(ms[i][15:8], ms[i][7:0]);
        check("pin two", {34'h0, int_two_oe, int_two_out}, 36'h3);
        wait_for(0, 1400);
        check("wake sample", sample_out, accel_in);
        $display("test motion switch done");
        foreach (ff[i]) wr(ff[i]);
        wait_for(1, 1000);
        check("pin one", {35'h0, int_one_oe}, 36'h1);
        rd(accel_pkg::ADDR_STATUS, 8'h60);
        $display("test free fall done");
        wr(16'h2c4b);
        repeat (30) @(negedge clk_sys);
        check("pin two drive", {35'h0, int_two_oe}, 36'h0);
        for (int t = 0; t < 2; t++) begin
            accel_in.z = accel_in.z + 12'sd7;
            ext_two = 1'b1;
            wait_for(0, 10);
            check("trigger sample", sample_out, accel_in);
            ext_two = 1'b0;
            repeat (20) @(negedge clk_sys);
        end
        $display("test trigger done");
        wr(16'h2c83);
        wr(16'h2d42);
        repeat (300) @(negedge clk_sys);
        k0 = n_samples;
        repeat (300) @(negedge clk_sys);
        check("pin one drive", {35'h0, int_one_oe}, 36'h0);
        check("stopped clock", 36'(n_samples - k0), 36'h0);
        repeat (1200) @(negedge clk_sys) ext_one = ~ext_one;
        check("external clock", 36'(n_samples - k0), 36'h1);
        $display("test external clock done");
        final_report();
    end
endmodule
bind accel_startup_configurator accel_startup_configurator_properties chk (.clk_sys, .reset_n, .spi_cs_n,
    .spi_miso_oe, .int_one_oe, .int_two_in, .int_two_oe, .accel_in, .sample_out, .sample_valid);
